/* File: shared/gbap_pkg.sv */
// Constants for the group B alarm power-down source register slice.
// Assumes a host-port register decoder upstream that presents word writes and reads.
package gbap_pkg;

    // ------------------------------------------------------------
    // Register map
    // ------------------------------------------------------------
    localparam logic [6:0]  GBAP_ADDR_DAC_SRC1 = 7'h49;
    localparam logic [6:0]  GBAP_ADDR_OUT_SRC0 = 7'h4A;
    localparam logic [15:0] GBAP_RST_DAC_SRC1  = 16'h1833;
    localparam logic [15:0] GBAP_RST_OUT_SRC0  = 16'h0000;
    localparam logic [15:0] GBAP_MASK_DAC_SRC1 = 16'h3833;
    localparam logic [15:0] GBAP_MASK_OUT_SRC0 = 16'h0133;

    // ------------------------------------------------------------
    // Field positions, group B converter source register
    // ------------------------------------------------------------
    localparam int GBAP_BIT_EXT_PIN  = 13;
    localparam int GBAP_BIT_REF      = 12;
    localparam int GBAP_BIT_THERMAL  = 11;
    localparam int GBAP_BIT_NEG_B    = 5;
    localparam int GBAP_BIT_NEG_A    = 4;
    localparam int GBAP_BIT_POS_B    = 1;
    localparam int GBAP_BIT_POS_A    = 0;

    // ------------------------------------------------------------
    // Field positions, output-switch group B source register
    // ------------------------------------------------------------
    localparam int GBAP_BIT_TEMP     = 8;
    localparam int GBAP_BIT_ADC1     = 5;
    localparam int GBAP_BIT_ADC0     = 4;
    localparam int GBAP_BIT_SENSE1   = 1;
    localparam int GBAP_BIT_SENSE0   = 0;

    // ------------------------------------------------------------
    // Sizes
    // ------------------------------------------------------------
    localparam int GBAP_REG_W        = 16;
    localparam int GBAP_ADDR_W       = 7;
    localparam int GBAP_CH_DEFAULT   = 4;
    localparam int GBAP_SYNC_STAGES  = 3;

endpackage

/* File: src/gbap_alarm_route.sv */
// Per-channel routing of enabled alarm sources into power-down requests.
// Assumes alarms arrive aligned to the source register field positions.
`timescale 1ns/10ps
module gbap_alarm_route
    import gbap_pkg::*;
#(
    parameter int NUM_CH = GBAP_CH_DEFAULT
) (
    input  wire logic [GBAP_REG_W-1:0] alarm_vec,
    input  wire logic [GBAP_REG_W-1:0] src_mask,
    input  wire logic [NUM_CH-1:0]     chan_enable,
    output wire logic                  any_hit,
    output wire logic [NUM_CH-1:0]     pd_req
);

    // Elaboration-time refusal of unsupported channel counts
    if (NUM_CH < 1 || NUM_CH > 8) begin : g_bad_ch
        $error("gbap_alarm_route: NUM_CH must be 1 to 8");
    end

    // ------------------------------------------------------------
    // Source gating
    // ------------------------------------------------------------
    wire logic [GBAP_REG_W-1:0] hit_vec;
    assign hit_vec = alarm_vec & src_mask;
    assign any_hit = |hit_vec;

    // ------------------------------------------------------------
    // Channel gating
    // ------------------------------------------------------------
    genvar ch;
    generate
        for (ch = 0; ch < NUM_CH; ch++) begin : g_ch
            assign pd_req[ch] = any_hit & chan_enable[ch];
        end
    endgenerate

endmodule // gbap_alarm_route

/* File: src/gbap_top.sv */
// Group B alarm power-down source registers and request generation.
// Assumes a host-port decoder on core_clk; alarm detectors other than the pin are on core_clk.
`timescale 1ns/10ps
module gbap_top
    import gbap_pkg::*;
#(
    parameter int NUM_CH = GBAP_CH_DEFAULT
) (
    input  wire logic                   core_clk,
    input  wire logic                   resetn,
    input  wire logic [GBAP_ADDR_W-1:0] reg_addr,
    input  wire logic [GBAP_REG_W-1:0]  reg_wdata,
    input  wire logic                   reg_wr,
    input  wire logic                   reg_rd,
    output logic      [GBAP_REG_W-1:0]  reg_rdata,
    output logic                        reg_rd_valid,
    input  wire logic                   ext_alarm_pin,
    input  wire logic                   reference_fault,
    input  wire logic                   thermal_error,
    input  wire logic                   neg_supply_b_alarm,
    input  wire logic                   neg_supply_a_alarm,
    input  wire logic                   pos_supply_b_alarm,
    input  wire logic                   pos_supply_a_alarm,
    input  wire logic [NUM_CH-1:0]      channel_autopowerdown_enable,
    output logic      [NUM_CH-1:0]      bias_converter_group_b_pd,
    output logic      [GBAP_REG_W-1:0]  dac_group_b_alarm_source_1,
    output logic      [GBAP_REG_W-1:0]  output_group_b_alarm_source_0
);

    // Elaboration-time refusal of unsupported channel counts
    if (NUM_CH < 1 || NUM_CH > 8) begin : g_bad_ch
        $error("gbap_top: NUM_CH must be 1 to 8");
    end

    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------
    logic [GBAP_REG_W-1:0]       dac_src1_r;
    logic [GBAP_REG_W-1:0]       dac_src1_nxt;
    logic [GBAP_REG_W-1:0]       out_src0_r;
    logic [GBAP_REG_W-1:0]       out_src0_nxt;
    logic [GBAP_REG_W-1:0]       rdata_r;
    logic [GBAP_REG_W-1:0]       rdata_nxt;
    logic                        rd_valid_r;
    logic [NUM_CH-1:0]           pd_r;
    logic [GBAP_SYNC_STAGES-1:0] ext_sync_r;
    logic                        ext_filt_r;
    logic                        ext_filt_nxt;

    // ------------------------------------------------------------
    // Address decode and write data
    // ------------------------------------------------------------
    wire logic sel_dac_src1;
    wire logic sel_out_src0;
    assign sel_dac_src1 = reg_addr == GBAP_ADDR_DAC_SRC1;
    assign sel_out_src0 = reg_addr == GBAP_ADDR_OUT_SRC0;

    // Reserved positions are masked off on write
    assign dac_src1_nxt = (reg_wr && sel_dac_src1) ? (reg_wdata & GBAP_MASK_DAC_SRC1) : dac_src1_r;
    assign out_src0_nxt = (reg_wr && sel_out_src0) ? (reg_wdata & GBAP_MASK_OUT_SRC0) : out_src0_r;

    // Unmapped addresses read zero
    assign rdata_nxt = !reg_rd      ? rdata_r    :
                       sel_dac_src1 ? dac_src1_r :
                       sel_out_src0 ? out_src0_r : 16'h0000;

    always_ff @(posedge core_clk) begin
        if (!resetn) begin
            dac_src1_r <= GBAP_RST_DAC_SRC1;
            out_src0_r <= GBAP_RST_OUT_SRC0;
            rdata_r    <= 16'h0000;
            rd_valid_r <= 1'b0;
        end else begin
            dac_src1_r <= dac_src1_nxt;
            out_src0_r <= out_src0_nxt;
            rdata_r    <= rdata_nxt;
            rd_valid_r <= reg_rd;
        end
    end

    // ------------------------------------------------------------
    // External alarm pin synchroniser and agreement filter
    // ------------------------------------------------------------
    assign ext_filt_nxt = (ext_sync_r[1] == ext_sync_r[2]) ? ext_sync_r[2] : ext_filt_r;

    always_ff @(posedge core_clk) begin
        if (!resetn) begin
            ext_sync_r <= 3'h0;
            ext_filt_r <= 1'b0;
        end else begin
            ext_sync_r <= {ext_sync_r[1:0], ext_alarm_pin};
            ext_filt_r <= ext_filt_nxt;
        end
    end

    // ------------------------------------------------------------
    // Alarm routing
    // ------------------------------------------------------------
    wire logic [GBAP_REG_W-1:0] alarm_vec;
    wire logic [NUM_CH-1:0]     pd_nxt;
    wire logic                  any_hit;

    assign alarm_vec = {2'b00, ext_filt_r, reference_fault, thermal_error, 5'b00000,
                        neg_supply_b_alarm, neg_supply_a_alarm, 2'b00,
                        pos_supply_b_alarm, pos_supply_a_alarm};

    gbap_alarm_route #(
        .NUM_CH      (NUM_CH)
    ) u_route (
        .alarm_vec   (alarm_vec),
        .src_mask    (dac_src1_r),
        .chan_enable (channel_autopowerdown_enable),
        .any_hit     (any_hit),
        .pd_req      (pd_nxt)
    );

    always_ff @(posedge core_clk) begin
        if (!resetn) begin
            pd_r <= '0;
        end else begin
            pd_r <= pd_nxt;
        end
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    assign reg_rdata                     = rdata_r;
    assign reg_rd_valid                  = rd_valid_r;
    assign bias_converter_group_b_pd     = pd_r;
    assign dac_group_b_alarm_source_1    = dac_src1_r;
    assign output_group_b_alarm_source_0 = out_src0_r;

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    property p_ext_route;
        @(posedge core_clk) disable iff (!resetn)
        (ext_filt_r && dac_src1_r[GBAP_BIT_EXT_PIN]) |=> (pd_r == $past(channel_autopowerdown_enable));
    endproperty
    a_ext_route: assert property (p_ext_route) else $error("ext pin alarm not routed");

    property p_ref_route;
        @(posedge core_clk) disable iff (!resetn)
        (reference_fault && dac_src1_r[GBAP_BIT_REF]) |=> (pd_r == $past(channel_autopowerdown_enable));
    endproperty
    a_ref_route: assert property (p_ref_route) else $error("reference alarm not routed");

    property p_therm_route;
        @(posedge core_clk) disable iff (!resetn)
        (thermal_error && dac_src1_r[GBAP_BIT_THERMAL]) |=> (pd_r == $past(channel_autopowerdown_enable));
    endproperty
    a_therm_route: assert property (p_therm_route) else $error("thermal alarm not routed");

    property p_negb_route;
        @(posedge core_clk) disable iff (!resetn)
        (neg_supply_b_alarm && dac_src1_r[GBAP_BIT_NEG_B]) |=> (pd_r == $past(channel_autopowerdown_enable));
    endproperty
    a_negb_route: assert property (p_negb_route) else $error("neg supply b alarm not routed");

    property p_nega_route;
        @(posedge core_clk) disable iff (!resetn)
        (neg_supply_a_alarm && dac_src1_r[GBAP_BIT_NEG_A]) |=> (pd_r == $past(channel_autopowerdown_enable));
    endproperty
    a_nega_route: assert property (p_nega_route) else $error("neg supply a alarm not routed");

    property p_posb_route;
        @(posedge core_clk) disable iff (!resetn)
        (pos_supply_b_alarm && dac_src1_r[GBAP_BIT_POS_B]) |=> (pd_r == $past(channel_autopowerdown_enable));
    endproperty
    a_posb_route: assert property (p_posb_route) else $error("pos supply b alarm not routed");

    property p_posa_route;
        @(posedge core_clk) disable iff (!resetn)
        (pos_supply_a_alarm && dac_src1_r[GBAP_BIT_POS_A]) |=> (pd_r == $past(channel_autopowerdown_enable));
    endproperty
    a_posa_route: assert property (p_posa_route) else $error("pos supply a alarm not routed");

    property p_blocked;
        @(posedge core_clk) disable iff (!resetn)
        ((alarm_vec & dac_src1_r) == 16'h0000) |=> (pd_r == '0);
    endproperty
    a_blocked: assert property (p_blocked) else $error("power-down without enabled alarm");

    property p_rst_out;
        @(posedge core_clk)
        !resetn |=> (out_src0_r == GBAP_RST_OUT_SRC0);
    endproperty
    a_rst_out: assert property (p_rst_out) else $error("output source register reset wrong");

    property p_rst_dac;
        @(posedge core_clk)
        !resetn |=> (dac_src1_r == GBAP_RST_DAC_SRC1);
    endproperty
    a_rst_dac: assert property (p_rst_dac) else $error("converter source register reset wrong");

    property p_reserved;
        @(posedge core_clk) disable iff (!resetn)
        reg_wr |=> ((dac_src1_r & ~GBAP_MASK_DAC_SRC1) == 16'h0000)
                   && ((out_src0_r & ~GBAP_MASK_OUT_SRC0) == 16'h0000);
    endproperty
    a_reserved: assert property (p_reserved) else $error("reserved bit set");

    property p_ext_filter;
        @(posedge core_clk) disable iff (!resetn)
        (ext_sync_r[2] != ext_sync_r[1]) |=> $stable(ext_filt_r);
    endproperty
    a_ext_filter: assert property (p_ext_filter) else $error("pin filter changed on disagreement");

    cv_pd: cover property (@(posedge core_clk) disable iff (!resetn) any_hit ##1 (pd_r != '0));
    cv_write_dac: cover property (@(posedge core_clk) disable iff (!resetn) reg_wr && sel_dac_src1);
    cv_read_out: cover property (@(posedge core_clk) disable iff (!resetn) reg_rd && sel_out_src0 ##1 rd_valid_r);
    cv_ext_pd: cover property (@(posedge core_clk) disable iff (!resetn) ext_filt_r && any_hit);

endmodule // gbap_top

/* File: dv/gbap_top_bench.sv */
// Self-checking bench for the group B alarm power-down source registers.
// Assumes gbap_pkg is compiled first; drives every input at the falling edge.
`timescale 1ns/10ps
module gbap_top_bench
    import gbap_pkg::*;
;
    localparam int NCH = 4;
    logic                   core_clk;
    logic                   resetn;
    logic [GBAP_ADDR_W-1:0] reg_addr;
    logic [GBAP_REG_W-1:0]  reg_wdata;
    logic                   reg_wr;
    logic                   reg_rd;
    logic [GBAP_REG_W-1:0]  reg_rdata;
    logic                   reg_rd_valid;
    logic [6:0]             alarms;
    logic [NCH-1:0]         chan_en;
    logic [NCH-1:0]         pd;
    logic [GBAP_REG_W-1:0]  dac_src;
    logic [GBAP_REG_W-1:0]  out_src;
    int                     err_count;
    int                     num_checks;
    int                     seed;
    int                     cycles;
    logic [15:0]            src;
    int                     bitpos [7] = '{13, 12, 11, 5, 4, 1, 0};

    gbap_top #(.NUM_CH(NCH)) gbap_top_inst (
        .core_clk                      (core_clk),
        .resetn                        (resetn),
        .reg_addr                      (reg_addr),
        .reg_wdata                     (reg_wdata),
        .reg_wr                        (reg_wr),
        .reg_rd                        (reg_rd),
        .reg_rdata                     (reg_rdata),
        .reg_rd_valid                  (reg_rd_valid),
        .ext_alarm_pin                 (alarms[0]),
        .reference_fault               (alarms[1]),
        .thermal_error                 (alarms[2]),
        .neg_supply_b_alarm            (alarms[3]),
        .neg_supply_a_alarm            (alarms[4]),
        .pos_supply_b_alarm            (alarms[5]),
        .pos_supply_a_alarm            (alarms[6]),
        .channel_autopowerdown_enable  (chan_en),
        .bias_converter_group_b_pd     (pd),
        .dac_group_b_alarm_source_1    (dac_src),
        .output_group_b_alarm_source_0 (out_src)
    );

    initial begin
        core_clk = 1'b0;
        forever #5 core_clk = ~core_clk;
    end

    // ------------------------------------------------------------
    // Checking and closing
    // ------------------------------------------------------------
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        num_checks++;
        if (seen !== exp) begin
            err_count++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", num_checks, err_count);
        if (err_count == 0 && num_checks > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    always @(posedge core_clk) begin
        cycles++;
        if (cycles == 8000) begin
            err_count++;
            tally_and_finish();
        end
    end

    // Expected request: any enabled alarm asserts every enabled channel
    function automatic logic [NCH-1:0] exp_pd(input logic [15:0] s, input logic [6:0] a,
                                              input logic [NCH-1:0] en);
        logic hit;
        hit = 1'b0;
        for (int i = 0; i < 7; i++) begin
            hit = hit | (a[i] & s[bitpos[i]]);
        end
        return hit ? en : '0;
    endfunction

    // ------------------------------------------------------------
    // Register strobes and alarm cases
    // ------------------------------------------------------------
    task automatic wr(input logic [6:0] a, input logic [15:0] d);
        reg_addr = a;
        reg_wdata = d;
        reg_wr = 1'b1;
        @(negedge core_clk);
        reg_wr = 1'b0;
        @(negedge core_clk);
    endtask

    task automatic rd(input logic [6:0] a, input logic [15:0] exp);
        reg_addr = a;
        reg_rd = 1'b1;
        @(negedge core_clk);
        reg_rd = 1'b0;
        check({15'h0000, reg_rd_valid}, 16'h0001);
        check(reg_rdata, exp);
        @(negedge core_clk);
    endtask

    task automatic alarm_case(input logic [15:0] s, input logic [6:0] a);
        chan_en = NCH'($random(seed));
        alarms = a;
        repeat (6) @(negedge core_clk);
        check({12'h000, pd}, {12'h000, exp_pd(s & GBAP_MASK_DAC_SRC1, a, chan_en)});
        alarms = '0;
        repeat (6) @(negedge core_clk);
        check({12'h000, pd}, 16'h0000);
    endtask

    initial begin
        seed = 10;
        err_count = 0;
        num_checks = 0;
        cycles = 0;
        resetn = 1'b0;
        reg_addr = '0;
        reg_wdata = '0;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        alarms = '0;
        chan_en = '0;
        repeat (20) @(negedge core_clk);
        resetn = 1'b1;
        check(dac_src, 16'h1833);
        check(out_src, 16'h0000);
        rd(GBAP_ADDR_DAC_SRC1, 16'h1833);
        rd(GBAP_ADDR_OUT_SRC0, 16'h0000);
        // One-cycle follow of an on-chip alarm
        chan_en = 4'h5;
        alarms = 7'h02;
        @(negedge core_clk);
        check({12'h000, pd}, 16'h0005);
        alarms = '0;
        @(negedge core_clk);
        check({12'h000, pd}, 16'h0000);
        // Enabled alarm with every channel disabled
        chan_en = 4'h0;
        alarms = 7'h02;
        @(negedge core_clk);
        check({12'h000, pd}, 16'h0000);
        alarms = '0;
        // Reset default blocks the pin alarm
        alarm_case(16'h1833, 7'h01);
        wr(GBAP_ADDR_DAC_SRC1, 16'hFFFF);
        rd(GBAP_ADDR_DAC_SRC1, 16'h3833);
        wr(GBAP_ADDR_OUT_SRC0, 16'hFFFF);
        rd(GBAP_ADDR_OUT_SRC0, 16'h0133);
        wr(7'h40, 16'h0000);
        rd(7'h40, 16'h0000);
        rd(GBAP_ADDR_DAC_SRC1, 16'h3833);
        // Each alarm alone, with its enable set and cleared
        for (int i = 0; i < 7; i++) begin
            for (int s = 0; s < 2; s++) begin
                src = s ? 16'hFFFF : ~(16'h0001 << bitpos[i]);
                wr(GBAP_ADDR_DAC_SRC1, src);
                check(dac_src, src & 16'h3833);
                alarm_case(src, 7'h01 << i);
            end
        end
        for (int n = 0; n < 40; n++) begin
            src = 16'($random(seed));
            wr(GBAP_ADDR_DAC_SRC1, src);
            alarm_case(src, 7'($random(seed)));
        end
        // Second reset in mid-run
        resetn = 1'b0;
        @(negedge core_clk);
        resetn = 1'b1;
        check(dac_src, 16'h1833);
        check(out_src, 16'h0000);
        tally_and_finish();
    end
endmodule // gbap_top_bench
